// ===== pga_amp_slice.sv
`timescale 1ns/10ps
`default_nettype none

module pga_amp_slice #(
  parameter int unsigned N_CHANNELS = 6
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        shift_en,
  input  wire logic        si,
  input  wire logic        latch_en,
  output logic             so,
  output logic [2:0]       gain_q,
  output logic [2:0]       channel_q,
  output logic             shutdown_q
);

  logic [15:0] shreg_q;
  logic [15:0] shreg_d;
  logic [2:0]  gain_d;
  logic [2:0]  channel_d;
  logic        shutdown_d;
  logic [2:0]  cmd;
  logic        addr;
  logic [2:0]  data;

  assign cmd  = shreg_q[pga_chain_pkg::CMD_MSB:pga_chain_pkg::CMD_LSB];
  assign addr = shreg_q[pga_chain_pkg::ADDR_POS];
  assign data = shreg_q[pga_chain_pkg::DATA_MSB:pga_chain_pkg::DATA_LSB];
  assign so   = shreg_q[15];

  always_comb begin
    shreg_d    = shreg_q;
    gain_d     = gain_q;
    channel_d  = channel_q;
    shutdown_d = shutdown_q;
    if (shift_en) begin
      shreg_d = {shreg_q[14:0], si};
    end
    if (latch_en) begin
      case (cmd)
        pga_chain_pkg::CMD_SHUTDOWN: begin
          shutdown_d = 1'h1;
        end
        pga_chain_pkg::CMD_WRITE: begin
          shutdown_d = 1'h0;
          if (addr == pga_chain_pkg::ADDR_GAIN) begin
            gain_d = data;
          end else if (N_CHANNELS > 1 && 32'(data) < N_CHANNELS) begin
            channel_d = data;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      shreg_q    <= 16'h0000;
      gain_q     <= pga_chain_pkg::GAIN_RST;
      channel_q  <= pga_chain_pkg::CHANNEL_RST;
      shutdown_q <= pga_chain_pkg::SHUTDOWN_RST;
    end else begin
      shreg_q    <= shreg_d;
      gain_q     <= gain_d;
      channel_q  <= channel_d;
      shutdown_q <= shutdown_d;
    end
  end

endmodule : pga_amp_slice

`default_nettype wire

// ===== pga_chain_chk.sv
`timescale 1ns/10ps
`default_nettype none

module pga_chain_chk #(
  parameter int unsigned UP_CHANNELS = 6
) (
  input wire logic                   clk,
  input wire logic                   rst_b,
  input wire logic                   cs_b,
  input wire logic                   sck,
  input wire logic                   si,
  input wire logic                   so_o,
  input wire logic                   so_oe,
  input wire logic [2:0]             up_gain_code,
  input wire logic [5:0]             up_gain_vv,
  input wire logic [2:0]             up_channel,
  input wire logic [UP_CHANNELS-1:0] up_mux_sel,
  input wire logic                   up_shutdown_code,
  input wire logic                   up_input_channel_zero,
  input wire logic [2:0]             dn_gain_code,
  input wire logic [5:0]             dn_gain_vv,
  input wire logic                   dn_shutdown_code,
  input wire logic                   frame_error
);
  localparam logic [5:0] VV [8] = '{6'h01, 6'h02, 6'h04, 6'h05, 6'h08, 6'h0A, 6'h10, 6'h20};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_sel_low; (!cs_b) [*4]; endsequence
  sequence s_sel_high; cs_b [*4]; endsequence
  sequence s_rise; $past(cs_b, 3) && $past(cs_b, 4) && !$past(cs_b, 9); endsequence

  property p_rst; $rose(rst_b) |-> up_gain_code == 3'h0 && up_channel == 3'h0 &&
    up_mux_sel == 6'h01 && !up_shutdown_code && dn_gain_code == 3'h0 && !dn_shutdown_code;
  endproperty
  property p_vv; $past(rst_b) |-> up_gain_vv == VV[$past(up_gain_code)] &&
    dn_gain_vv == VV[$past(dn_gain_code)]; endproperty
  property p_mux; $past(rst_b) |-> up_mux_sel ==
    ($past(up_shutdown_code) ? 6'h00 : 6'h01 << $past(up_channel)); endproperty
  property p_chan; up_channel < UP_CHANNELS && up_input_channel_zero == (up_channel == 3'h0);
  endproperty
  property p_latch; $changed({up_gain_code, up_channel, up_shutdown_code, dn_gain_code,
    dn_shutdown_code}) |-> s_rise; endproperty
  property p_oe_on; s_sel_low |=> so_oe; endproperty
  property p_oe_off; s_sel_high |=> !so_oe; endproperty

  a_rst: assert property (p_rst) else $error("reset defaults wrong");
  a_vv: assert property (p_vv) else $error("gain value does not match code");
  a_mux: assert property (p_mux) else $error("selector does not match channel");
  a_chan: assert property (p_chan) else $error("channel out of range");
  a_latch: assert property (p_latch) else $error("setting changed without select rise");
  a_oe_on: assert property (p_oe_on) else $error("serial out not driven in frame");
  a_oe_off: assert property (p_oe_off) else $error("serial out driven when idle");
endmodule : pga_chain_chk

bind pga_spi_daisy_chain_ctrl pga_chain_chk #(
  .UP_CHANNELS (UP_CHANNELS)
) pga_chain_chk_inst (
  .clk                   (clk),
  .rst_b                 (rst_b),
  .cs_b                  (cs_b),
  .sck                   (sck),
  .si                    (si),
  .so_o                  (so_o),
  .so_oe                 (so_oe),
  .up_gain_code          (up_gain_code),
  .up_gain_vv            (up_gain_vv),
  .up_channel            (up_channel),
  .up_mux_sel            (up_mux_sel),
  .up_shutdown_code      (up_shutdown_code),
  .up_input_channel_zero (up_input_channel_zero),
  .dn_gain_code          (dn_gain_code),
  .dn_gain_vv            (dn_gain_vv),
  .dn_shutdown_code      (dn_shutdown_code),
  .frame_error           (frame_error)
);

`default_nettype wire

// ===== pga_chain_pkg.sv
package pga_chain_pkg;

  localparam int unsigned WORD_BITS   = 16;
  localparam int unsigned FRAME_BITS  = 32;
  localparam int unsigned CODE_BITS   = 3;
  localparam int unsigned CNT_BITS    = 6;
  localparam int unsigned SYNC_STAGES = 2;

  // Word layout: instruction byte on top, data byte below
  localparam int unsigned CMD_MSB     = 15;
  localparam int unsigned CMD_LSB     = 13;
  localparam int unsigned ADDR_POS    = 8;
  localparam int unsigned DATA_MSB    = 2;
  localparam int unsigned DATA_LSB    = 0;

  localparam logic [2:0] CMD_NOP      = 3'h0;
  localparam logic [2:0] CMD_SHUTDOWN = 3'h1;
  localparam logic [2:0] CMD_WRITE    = 3'h2;
  localparam logic       ADDR_GAIN    = 1'h0;
  localparam logic       ADDR_CHANNEL = 1'h1;

  localparam logic [2:0] GAIN_RST     = 3'h0;
  localparam logic [2:0] CHANNEL_RST  = 3'h0;
  localparam logic       SHUTDOWN_RST = 1'h0;
  localparam logic [5:0] CNT_RST      = 6'h00;

  localparam int unsigned UP_CHANNELS = 6;
  localparam int unsigned DN_CHANNELS = 1;

  typedef enum logic [1:0] {
    LINK_IDLE,
    LINK_SHIFT,
    LINK_LATCH
  } link_state_t;

  function automatic logic [5:0] gain_vv(input logic [2:0] code);
    case (code)
      3'h0:    gain_vv = 6'h01;
      3'h1:    gain_vv = 6'h02;
      3'h2:    gain_vv = 6'h04;
      3'h3:    gain_vv = 6'h05;
      3'h4:    gain_vv = 6'h08;
      3'h5:    gain_vv = 6'h0A;
      3'h6:    gain_vv = 6'h10;
      default: gain_vv = 6'h20;
    endcase
  endfunction : gain_vv

endpackage : pga_chain_pkg

// ===== pga_spi_daisy_chain_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

module pga_spi_daisy_chain_ctrl #(
  parameter int unsigned UP_CHANNELS = pga_chain_pkg::UP_CHANNELS
) (
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic                   cs_b,
  input  wire logic                   sck,
  input  wire logic                   si,
  output logic                        so_o,
  output logic                        so_oe,
  output logic [2:0]                  up_gain_code,
  output logic [5:0]                  up_gain_vv,
  output logic [2:0]                  up_channel,
  output logic [UP_CHANNELS-1:0]      up_mux_sel,
  output logic                        up_shutdown_code,
  output logic                        up_input_channel_zero,
  output logic [2:0]                  dn_gain_code,
  output logic [5:0]                  dn_gain_vv,
  output logic                        dn_shutdown_code,
  output logic                        frame_error
);

  // Pin synchronisers
  logic [1:0] cs_sync_q;
  logic [1:0] sck_sync_q;
  logic [1:0] si_sync_q;
  logic [1:0] cs_sync_d;
  logic [1:0] sck_sync_d;
  logic [1:0] si_sync_d;
  logic       cs_b_s;
  logic       sck_s;
  logic       si_s;

  // Link state
  pga_chain_pkg::link_state_t state_q;
  pga_chain_pkg::link_state_t state_d;
  logic                       sck_prev_q;
  logic                       sck_prev_d;
  logic [5:0]                 bit_cnt_q;
  logic [5:0]                 bit_cnt_d;
  logic                       frame_error_q;
  logic                       frame_error_d;
  logic                       shift_en;
  logic                       latch_en;
  logic                       sck_rise;

  // Output registers
  logic [5:0]                 up_gain_vv_q;
  logic [5:0]                 dn_gain_vv_q;
  logic [UP_CHANNELS-1:0]     up_mux_q;
  logic [UP_CHANNELS-1:0]     up_mux_d;
  logic                       chain_mid;
  logic                       dn_so;
  logic [2:0]                 up_gain_w;
  logic [2:0]                 up_chan_w;
  logic                       up_sd_w;
  logic [2:0]                 dn_gain_w;
  logic                       dn_sd_w;

  always_comb begin
    cs_sync_d  = {cs_sync_q[0], cs_b};
    sck_sync_d = {sck_sync_q[0], sck};
    si_sync_d  = {si_sync_q[0], si};
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cs_sync_q  <= 2'h3;
      sck_sync_q <= 2'h0;
      si_sync_q  <= 2'h0;
    end else begin
      cs_sync_q  <= cs_sync_d;
      sck_sync_q <= sck_sync_d;
      si_sync_q  <= si_sync_d;
    end
  end

  assign cs_b_s   = cs_sync_q[1];
  assign sck_s    = sck_sync_q[1];
  assign si_s     = si_sync_q[1];
  assign sck_rise = sck_s && !sck_prev_q;

  // Frame tracking; latch only on whole 16-bit multiples
  always_comb begin
    state_d       = state_q;
    bit_cnt_d     = bit_cnt_q;
    frame_error_d = frame_error_q;
    shift_en      = 1'h0;
    latch_en      = 1'h0;
    sck_prev_d    = sck_s;
    case (state_q)
      pga_chain_pkg::LINK_IDLE: begin
        if (!cs_b_s) begin
          bit_cnt_d = pga_chain_pkg::CNT_RST;
          state_d   = pga_chain_pkg::LINK_SHIFT;
        end
      end
      pga_chain_pkg::LINK_SHIFT: begin
        if (cs_b_s) begin
          state_d = pga_chain_pkg::LINK_LATCH;
        end else if (sck_rise) begin
          shift_en = 1'h1;
          if (bit_cnt_q != 6'h3F) begin
            bit_cnt_d = bit_cnt_q + 6'h01;
          end
        end
      end
      pga_chain_pkg::LINK_LATCH: begin
        if (bit_cnt_q != 6'h00 && bit_cnt_q[3:0] == 4'h0) begin
          latch_en      = 1'h1;
          frame_error_d = 1'h0;
        end else begin
          frame_error_d = 1'h1;
        end
        state_d = pga_chain_pkg::LINK_IDLE;
      end
      default: begin
        state_d = pga_chain_pkg::LINK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q       <= pga_chain_pkg::LINK_IDLE;
      bit_cnt_q     <= pga_chain_pkg::CNT_RST;
      frame_error_q <= 1'h0;
      sck_prev_q    <= 1'h0;
    end else begin
      state_q       <= state_d;
      bit_cnt_q     <= bit_cnt_d;
      frame_error_q <= frame_error_d;
      sck_prev_q    <= sck_prev_d;
    end
  end

  // Upstream amplifier, first on the chain
  pga_amp_slice #(
    .N_CHANNELS (UP_CHANNELS)
  ) u_up (
    .clk        (clk),
    .rst_b      (rst_b),
    .shift_en   (shift_en),
    .si         (si_s),
    .latch_en   (latch_en),
    .so         (chain_mid),
    .gain_q     (up_gain_w),
    .channel_q  (up_chan_w),
    .shutdown_q (up_sd_w)
  );

  // Downstream amplifier fed from upstream serial out
  pga_amp_slice #(
    .N_CHANNELS (pga_chain_pkg::DN_CHANNELS)
  ) u_dn (
    .clk        (clk),
    .rst_b      (rst_b),
    .shift_en   (shift_en),
    .si         (chain_mid),
    .latch_en   (latch_en),
    .so         (dn_so),
    .gain_q     (dn_gain_w),
    .channel_q  (),
    .shutdown_q (dn_sd_w)
  );

  // Selector for the six inputs: one-hot, or all zero in shutdown
  genvar g;
  generate
    for (g = 0; g < UP_CHANNELS; g++) begin : g_mux
      always_comb begin
        up_mux_d[g] = !up_sd_w && (32'(up_chan_w) == g);
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      up_gain_vv_q <= pga_chain_pkg::gain_vv(pga_chain_pkg::GAIN_RST);
      dn_gain_vv_q <= pga_chain_pkg::gain_vv(pga_chain_pkg::GAIN_RST);
      up_mux_q     <= UP_CHANNELS'(1);
    end else begin
      up_gain_vv_q <= pga_chain_pkg::gain_vv(up_gain_w);
      dn_gain_vv_q <= pga_chain_pkg::gain_vv(dn_gain_w);
      up_mux_q     <= up_mux_d;
    end
  end

  assign so_o                  = dn_so;
  assign so_oe                 = !cs_b_s;
  assign up_gain_code          = up_gain_w;
  assign up_gain_vv            = up_gain_vv_q;
  assign up_channel            = up_chan_w;
  assign up_mux_sel            = up_mux_q;
  assign up_shutdown_code      = up_sd_w;
  assign up_input_channel_zero = (up_chan_w == 3'h0);
  assign dn_gain_code          = dn_gain_w;
  assign dn_gain_vv            = dn_gain_vv_q;
  assign dn_shutdown_code      = dn_sd_w;
  assign frame_error           = frame_error_q;

endmodule : pga_spi_daisy_chain_ctrl

`default_nettype wire

// ===== spi_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module spi_host_model (
  input  wire logic clk,
  output logic      cs_b,
  output logic      sck,
  output logic      si
);
  // Pulled-up lines rest high, clock stands still low between frames
  initial begin
    cs_b = 1'b1;
    sck  = 1'b0;
    si   = 1'b1;
  end

  // Frame for a five-bit switch code, top switch first
  function automatic logic [31:0] frame_for(input logic [4:0] sw);
    logic [15:0] w;
    w = {3'h2, 4'h0, sw[4], 5'h00, sw[2:0]};
    case (sw[4:3])
      2'b01:   frame_for = {w, 16'h0000};
      2'b11:   frame_for = {(sw[1] | sw[0]) ? 16'h2000 : 16'h0000,
                            (sw[1] | !sw[0]) ? 16'h2000 : 16'h0000};
      default: frame_for = {16'h0000, w};
    endcase
  endfunction : frame_for

  // Shifts the top n bits, MSB first, hp clocks per clock phase
  task automatic send(input logic [31:0] w, input int n, input int hp);
    @(posedge clk);
    #1 cs_b = 1'b0;
    for (int i = 0; i < n; i++) begin
      si = w[31-i];
      repeat (hp) @(posedge clk);
      #1 sck = 1'b1;
      repeat (hp) @(posedge clk);
      #1 sck = 1'b0;
    end
    repeat (hp) @(posedge clk);
    #1 cs_b = 1'b1;
    si = 1'b1;
    repeat (8) @(posedge clk);
  endtask : send

  // One press and release of the read button
  task automatic press_release(input logic [4:0] sw_pins, input int hp);
    logic [4:0] sw_taken;
    repeat (6) @(posedge clk);
    sw_taken = sw_pins;
    send(frame_for(sw_taken), 32, hp);
  endtask : press_release
endmodule : spi_host_model

`default_nettype wire

// ===== testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
  localparam logic [5:0] VV [8] = '{6'h01, 6'h02, 6'h04, 6'h05, 6'h08, 6'h0A, 6'h10, 6'h20};
  logic       clk, rst_b, cs_b, sck, si, so_o, so_oe, frame_error;
  logic [2:0] up_gain_code, up_channel, dn_gain_code, eug, euc, edg;
  logic [5:0] up_gain_vv, up_mux_sel, dn_gain_vv;
  logic       up_shutdown_code, up_input_channel_zero, dn_shutdown_code, eus, eds;
  logic [4:0] sw;
  int         fail_count, num_checks;

  pga_spi_daisy_chain_ctrl pga_spi_daisy_chain_ctrl_inst (
    .clk                   (clk),
    .rst_b                 (rst_b),
    .cs_b                  (cs_b),
    .sck                   (sck),
    .si                    (si),
    .so_o                  (so_o),
    .so_oe                 (so_oe),
    .up_gain_code          (up_gain_code),
    .up_gain_vv            (up_gain_vv),
    .up_channel            (up_channel),
    .up_mux_sel            (up_mux_sel),
    .up_shutdown_code      (up_shutdown_code),
    .up_input_channel_zero (up_input_channel_zero),
    .dn_gain_code          (dn_gain_code),
    .dn_gain_vv            (dn_gain_vv),
    .dn_shutdown_code      (dn_shutdown_code),
    .frame_error           (frame_error)
  );
  spi_host_model spi_host_model_inst (.clk(clk), .cs_b(cs_b), .sck(sck), .si(si));

  always #20 clk = ~clk;

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp

  task automatic check_state(input logic err);
    #1;
    cmp(up_gain_code, eug);
    cmp(up_gain_vv, VV[eug]);
    cmp(up_channel, euc);
    cmp(up_mux_sel, eus ? 6'h00 : 6'h01 << euc);
    cmp(up_input_channel_zero, euc == 3'h0);
    cmp(up_shutdown_code, eus);
    cmp(dn_gain_code, edg);
    cmp(dn_gain_vv, VV[edg]);
    cmp(dn_shutdown_code, eds);
    cmp(frame_error, err);
    cmp(so_oe, 1'b0);
  endtask : check_state

  task automatic test_reset;
    rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    {eug, euc, edg, eus, eds} = '0;
    check_state(1'b0);
    cmp(so_o, 1'b0);
  endtask : test_reset

  task automatic test_refused;
    spi_host_model_inst.send(32'hFFFF_F000, 20, 4);
    check_state(1'b1);
    spi_host_model_inst.send(32'hFFFF_F000, 20, 4);
    check_state(1'b1);
    cmp(so_o, 1'b1);
    spi_host_model_inst.send({16'h4102, 16'h4004}, 32, 3);
    eug = 3'h4;
    check_state(1'b0);
    cmp(so_o, 1'b0);
    spi_host_model_inst.send(32'h4101_0000, 16, 5);
    euc = 3'h1;
    edg = 3'h4;
    check_state(1'b0);
  endtask : test_refused

  task automatic test_codes;
    for (int s = 0; s < 27; s++) begin
      sw = s[4:0];
      case (sw[4:3])
        2'b00: begin
          eug = sw[2:0];
          eus = 1'b0;
        end
        2'b01: begin
          edg = sw[2:0];
          eds = 1'b0;
        end
        2'b10: begin
          if (sw[2:0] < 3'h6) begin
            euc = sw[2:0];
          end
          eus = 1'b0;
        end
        default: begin
          eus |= sw[1] | !sw[0];
          eds |= sw[1] | sw[0];
        end
      endcase
      spi_host_model_inst.press_release(sw, 3 + 2 * (s % 2));
      check_state(1'b0);
    end
    spi_host_model_inst.press_release(5'h00, 3);
    eug = 3'h0;
    eus = 1'b0;
    check_state(1'b0);
  endtask : test_codes

  initial begin
    repeat (50000) @(posedge clk);
    fail_count++;
    finish_test();
  end

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    fail_count = 0;
    num_checks = 0;
    @(posedge clk);
    #1;
    test_reset();
    test_refused();
    test_codes();
    test_reset();
    finish_test();
  end
endmodule : testbench

`default_nettype wire
